// *** hdl/isrp_pkg.sv ***
// Constants, types and address decoding for the serial register port.
// Assumes one system clock; the register file sits outside on the same clock.
package isrp_pkg;

  // ----------------------------------------------------------------
  // Bus addresses and byte framing
  // ----------------------------------------------------------------
  localparam logic [7:0] ISRP_SLAVE_WR = 8'h90;
  localparam logic [7:0] ISRP_SLAVE_RD = 8'h91;
  localparam logic [3:0] ISRP_BYTE_BITS = 4'h8;
  localparam logic [3:0] ISRP_CNT_RST = 4'h0;
  localparam logic [7:0] ISRP_BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Register map limits
  // ----------------------------------------------------------------
  localparam logic [7:0] ISRP_REG_FIRST = 8'h02;
  localparam logic [7:0] ISRP_REG_LAST = 8'h27;
  localparam logic [7:0] ISRP_PTR_RST = 8'h02;
  localparam logic [7:0] ISRP_RO_STATUS = 8'h02;
  localparam logic [7:0] ISRP_RO_CHARGE = 8'h0A;
  localparam logic [7:0] ISRP_RO_CONV_HI = 8'h1F;
  localparam logic [7:0] ISRP_RO_CONV_LO = 8'h20;

  typedef enum {
    ISRP_WAIT, ISRP_RX_ADDR, ISRP_RX_CMD, ISRP_RX_DATA, ISRP_ACK, ISRP_TX, ISRP_TX_ACK
  } isrp_state_e;

  typedef enum {
    ISRP_K_ADDR_W, ISRP_K_ADDR_R, ISRP_K_CMD, ISRP_K_DATA, ISRP_K_NACK
  } isrp_kind_e;

  // A location that may be pointed at and read; the factory area is excluded.
  function automatic logic isrp_readable(input logic [7:0] a);
    isrp_readable = (a >= ISRP_REG_FIRST) && (a <= ISRP_REG_LAST);
  endfunction

  // A location that also accepts a written byte.
  function automatic logic isrp_writable(input logic [7:0] a);
    isrp_writable = isrp_readable(a) && (a != ISRP_RO_STATUS) && (a != ISRP_RO_CHARGE)
      && (a != ISRP_RO_CONV_HI) && (a != ISRP_RO_CONV_LO);
  endfunction

endpackage

// *** hdl/isrp_slave.sv ***
// Two-wire slave engine giving single-byte access to the register file.
// Assumes SCL and SDA arrive from pins and that the host is the only master.
`timescale 1ns/1ps

// Operation
// - Data changes only while clock is low
// - Every byte is eight bits plus acknowledge
// - Device pulls data low to acknowledge
// - Data line released after every acknowledge slot except a read-address ack, which drives data bit 7
// - Read: address, pointer, repeated start, data
// - Allowed pointer loads and acks, otherwise nack
// - Write commits only at closing acknowledge
// - Start or stop before ack discards write
// - Read returns register at current pointer
// - Stop returns to wait, lines ignored
// - Repeated start handled like plain start
// - Foreign slave address is not acknowledged
// - Reserved pointer nacked, pointer left unchanged
// - Read-only write: ack pointer, nack data
// - Only slave addresses 0x90 and 0x91 are acknowledged
// - Byte after write address is pointer
module isrp_slave
  import isrp_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Register file side
  output logic [7:0] REG_PTR,
  input wire logic [7:0] REG_RDATA,
  output logic REG_WR_STB,
  output logic [7:0] REG_WR_DATA
);

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_ff, sda_sync_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], SCL_IN};
      sda_sync_ff <= {sda_sync_ff[1:0], SDA_IN};
    end
  end

  assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  // A data edge while the clock stays high is a bus condition.
  assign bus_start = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_sync_ff[1];
  assign bus_stop = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_sync_ff[1];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  isrp_state_e state_ff, nxt_state;
  isrp_kind_e kind_ff, nxt_kind;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic sda_low_ff, nxt_sda_low;
  logic wr_stb_ff, nxt_wr_stb, byte_done;

  assign byte_done = scl_fall && (cnt_ff == ISRP_BYTE_BITS);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_wdata = wdata_ff;
    nxt_sda_low = sda_low_ff;
    nxt_wr_stb = 1'b0;
    if (bus_stop)
    begin
      // Stop wins over any state; a pending write byte is dropped.
      nxt_state = ISRP_WAIT;
      nxt_sda_low = 1'b0;
    end
    else if (bus_start)
    begin
      // A repeated start restarts address reception like any start.
      nxt_state = ISRP_RX_ADDR;
      nxt_cnt = ISRP_CNT_RST;
      nxt_sda_low = 1'b0;
    end
    else
    begin
      case (state_ff)
        ISRP_WAIT: nxt_sda_low = 1'b0;
        ISRP_RX_ADDR, ISRP_RX_CMD, ISRP_RX_DATA:
        begin
          if (scl_rise && (cnt_ff != ISRP_BYTE_BITS))
          begin
            nxt_sh = {sh_ff[6:0], sda_sync_ff[1]};
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (byte_done)
          begin
            nxt_state = ISRP_ACK;
            nxt_kind = ISRP_K_NACK;
            nxt_sda_low = 1'b0;
            if (state_ff == ISRP_RX_ADDR)
            begin
              if (sh_ff == ISRP_SLAVE_WR)
              begin
                nxt_kind = ISRP_K_ADDR_W;
                nxt_sda_low = 1'b1;
              end
              else if (sh_ff == ISRP_SLAVE_RD)
              begin
                nxt_kind = ISRP_K_ADDR_R;
                nxt_sda_low = 1'b1;
              end
            end
            else if (state_ff == ISRP_RX_CMD)
            begin
              // The byte after a write address is the register pointer.
              if (isrp_readable(sh_ff))
              begin
                nxt_ptr = sh_ff;
                nxt_kind = ISRP_K_CMD;
                nxt_sda_low = 1'b1;
              end
            end
            else if (isrp_writable(ptr_ff))
            begin
              nxt_wdata = sh_ff;
              nxt_kind = ISRP_K_DATA;
              nxt_sda_low = 1'b1;
            end
          end
        end
        ISRP_ACK:
        begin
          if (scl_fall)
          begin
            // Line is let go at the end of every acknowledge slot, except a read-address ack, which drives data bit 7.
            nxt_sda_low = 1'b0;
            nxt_cnt = ISRP_CNT_RST;
            nxt_state = ISRP_WAIT;
            case (kind_ff)
              ISRP_K_ADDR_W: nxt_state = ISRP_RX_CMD;
              ISRP_K_CMD: nxt_state = ISRP_RX_DATA;
              ISRP_K_ADDR_R:
              begin
                // Read serves whatever the pointer holds now.
                nxt_state = ISRP_TX;
                nxt_sh = {REG_RDATA[6:0], 1'b0};
                nxt_sda_low = ~REG_RDATA[7];
              end
              ISRP_K_DATA: nxt_wr_stb = 1'b1;
              default: nxt_state = ISRP_WAIT;
            endcase
          end
        end
        ISRP_TX:
        begin
          if (scl_rise)
            nxt_cnt = cnt_ff + 4'h1;
          if (byte_done)
          begin
            nxt_state = ISRP_TX_ACK;
            nxt_sda_low = 1'b0;
          end
          else if (scl_fall)
          begin
            // Next bit goes out only while the clock is low.
            nxt_sda_low = ~sh_ff[7];
            nxt_sh = {sh_ff[6:0], 1'b0};
          end
        end
        ISRP_TX_ACK:
        begin
          // Single-byte reads only; the host answer is not used.
          if (scl_fall)
            nxt_state = ISRP_WAIT;
        end
        default:
        begin
          nxt_state = ISRP_WAIT;
          nxt_sda_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_ff <= ISRP_WAIT;
      kind_ff <= ISRP_K_NACK;
      cnt_ff <= ISRP_CNT_RST;
      sh_ff <= ISRP_BYTE_RST;
      ptr_ff <= ISRP_PTR_RST;
      wdata_ff <= ISRP_BYTE_RST;
      sda_low_ff <= 1'b0;
      wr_stb_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      kind_ff <= nxt_kind;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      wdata_ff <= nxt_wdata;
      sda_low_ff <= nxt_sda_low;
      wr_stb_ff <= nxt_wr_stb;
    end
  end

  // Open drain: the pad only ever pulls low.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_ff;
  assign REG_PTR = ptr_ff;
  assign REG_WR_STB = wr_stb_ff;
  assign REG_WR_DATA = wdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_ack_own_addr;
    (state_ff == ISRP_RX_ADDR && byte_done && (sh_ff == ISRP_SLAVE_WR || sh_ff == ISRP_SLAVE_RD))
      |=> SDA_OE && state_ff == ISRP_ACK;
  endproperty
  a_ack_own_addr: assert property (p_ack_own_addr) else $error("own address not acked");
  property p_nack_foreign;
    (state_ff == ISRP_RX_ADDR && byte_done && sh_ff != ISRP_SLAVE_WR && sh_ff != ISRP_SLAVE_RD)
      |=> !SDA_OE && kind_ff == ISRP_K_NACK;
  endproperty
  a_nack_foreign: assert property (p_nack_foreign) else $error("foreign address acked");
  property p_release_after_ack;
    (state_ff == ISRP_ACK && scl_fall && kind_ff != ISRP_K_ADDR_R) |=> !SDA_OE;
  endproperty
  a_release_after_ack: assert property (p_release_after_ack) else $error("line held");
  property p_stop_to_wait;
    bus_stop |=> state_ff == ISRP_WAIT && !SDA_OE;
  endproperty
  a_stop_to_wait: assert property (p_stop_to_wait) else $error("stop did not idle");
  property p_start_restart;
    bus_start |=> state_ff == ISRP_RX_ADDR && cnt_ff == ISRP_CNT_RST;
  endproperty
  a_start_restart: assert property (p_start_restart) else $error("start not honoured");
  property p_bad_ptr_kept;
    (state_ff == ISRP_RX_CMD && byte_done && !isrp_readable(sh_ff))
      |=> $stable(REG_PTR) && !SDA_OE;
  endproperty
  a_bad_ptr_kept: assert property (p_bad_ptr_kept) else $error("bad pointer taken");
  property p_ptr_load;
    (state_ff == ISRP_RX_CMD && byte_done && isrp_readable(sh_ff))
      |=> REG_PTR == $past(sh_ff) && SDA_OE;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_commit_at_ack;
    !(state_ff == ISRP_ACK && kind_ff == ISRP_K_DATA && scl_fall) |=> !REG_WR_STB;
  endproperty
  a_commit_at_ack: assert property (p_commit_at_ack) else $error("write off the ack");
  property p_ro_nack;
    (state_ff == ISRP_RX_DATA && byte_done && !isrp_writable(ptr_ff))
      |=> !SDA_OE && kind_ff == ISRP_K_NACK;
  endproperty
  a_ro_nack: assert property (p_ro_nack) else $error("read-only write taken");
  property p_sda_change_low;
    ($changed(sda_low_ff) && !$past(bus_start) && !$past(bus_stop)) |-> !$past(scl_sync_ff[1]);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved, scl high");

  c_write: cover property (REG_WR_STB);
  c_read: cover property (state_ff == ISRP_TX_ACK && scl_fall);
  c_foreign: cover property (state_ff == ISRP_ACK && kind_ff == ISRP_K_NACK && scl_fall);
  c_restart: cover property (state_ff == ISRP_RX_DATA ##1 bus_start);

endmodule

// *** verification/isrp_host.sv ***
// Behavioural two-wire bus master that owns the serial clock.
// Assumes the data wire is resolved outside, with a pull-up, and fed back.
`timescale 1ns/1ps
module isrp_host (
  // Clock
  input wire logic clk,
  // Bus
  output logic scl,
  output logic sda,
  input wire logic sda_wire
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Six cycles low and six high, so the slave's late answer lands while low.
  task automatic bit_io(input logic d, output logic q);
    wt(3);
    sda = d;
    wt(3);
    scl = 1'b1;
    wt(6);
    q = sda_wire;
    scl = 1'b0;
  endtask

  task automatic start();
    wt(3);
    sda = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(6);
    sda = 1'b0;
    wt(6);
    scl = 1'b0;
  endtask

  task automatic stop();
    wt(3);
    sda = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(6);
    sda = 1'b1;
    wt(6);
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q);
    bit_io(1'b1, q);
    ack = ~q;
  endtask

  task automatic get(output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, q);
      b[i] = q;
    end
    bit_io(1'b1, q);
  endtask
endmodule

// *** verification/tb_i2c_slave_register_port.sv ***
// Self-checking bench for the serial register port with a small register file.
// Assumes the host model drives the bus at the falling clock edge.
`timescale 1ns/1ps
module tb_i2c_slave_register_port;
  import isrp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_h, sda_oe, sda_out, stb, scl_d, oe_d, ack;
  logic [7:0] ptr, wdata, rdata, b;
  logic [7:0] regs [0:63];
  int errors = 0;
  int n_checks = 0;
  int n_stb = 0;
  int cyc = 0;
  int n0;
  wire sda_wire = sda_h & (sda_oe ? sda_out : 1'b1);
  assign rdata = regs[ptr[5:0]];

  always #10 clk_sys = ~clk_sys;

  isrp_slave dut_u (.CLK_SYS(clk_sys), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .REG_PTR(ptr), .REG_RDATA(rdata),
    .REG_WR_STB(stb), .REG_WR_DATA(wdata));
  isrp_host host_u (.clk(clk_sys), .scl(scl), .sda(sda_h), .sda_wire(sda_wire));

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail(input string msg);
    errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
      fail(msg);
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp)
      fail(msg);
  endtask

  // The register file takes strobed writes; the slave must never move data under a high clock.
  always @(posedge clk_sys)
  begin
    cyc++;
    // The register file comes up with a recognisable pattern while reset is held.
    if (rst)
      for (int i = 0; i < 64; i++)
        regs[i] <= 8'(i) ^ 8'h5A;
    else if (stb === 1'b1)
    begin
      n_stb++;
      regs[ptr[5:0]] <= wdata;
    end
    if (scl && scl_d && (sda_oe !== oe_d))
      fail("slave data moved while clock high");
    scl_d <= scl;
    oe_d <= sda_oe;
    if (cyc == 20000)
    begin
      fail("timeout");
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  task automatic sel(input logic [7:0] a, input logic e);
    host_u.start();
    host_u.put(a, ack);
    chk1(ack, e, "address ack");
  endtask

  task automatic tx(input logic [7:0] d, input logic e);
    host_u.put(d, ack);
    chk1(ack, e, "byte ack");
  endtask

  task automatic rd(input logic [7:0] e);
    host_u.get(b);
    chk8(b, e, "read data");
  endtask

  task automatic strobes(input int e);
    host_u.wt(6);
    chk8(8'(n_stb - n0), 8'(e), "strobe count");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk8(ptr, ISRP_PTR_RST, "reset pointer");
    chk1(sda_oe, 1'b0, "reset drive");
    chk1(sda_out, 1'b0, "open-drain level");
    chk1(stb, 1'b0, "reset strobe");
    sel(ISRP_SLAVE_RD, 1'b1);
    rd(8'h02 ^ 8'h5A);
    host_u.stop();
  endtask

  task automatic t_write();
    sel(ISRP_SLAVE_WR, 1'b1);
    tx(8'h05, 1'b1);
    n0 = n_stb;
    tx(8'hA5, 1'b1);
    strobes(1);
    chk8(wdata, 8'hA5, "write data");
    chk8(ptr, 8'h05, "write pointer");
    chk1(sda_oe, 1'b0, "released after ack");
    host_u.stop();
    sel(ISRP_SLAVE_RD, 1'b1);
    rd(8'hA5);
    host_u.stop();
  endtask

  task automatic t_restart();
    sel(ISRP_SLAVE_WR, 1'b1);
    tx(8'h07, 1'b1);
    tx(8'h3C, 1'b1);
    sel(ISRP_SLAVE_RD, 1'b1);
    rd(8'h3C);
    sel(ISRP_SLAVE_WR, 1'b1);
    tx(8'h0A, 1'b1);
    sel(ISRP_SLAVE_RD, 1'b1);
    rd(8'h0A ^ 8'h5A);
    host_u.stop();
  endtask

  task automatic t_foreign();
    logic [7:0] l [5] = '{8'h00, 8'h92, 8'h10, 8'h01, 8'h11};
    foreach (l[i])
    begin
      sel(l[i], 1'b0);
      host_u.stop();
    end
  endtask

  task automatic t_reserved();
    logic [7:0] l [5] = '{8'h00, 8'h01, 8'h28, 8'h2E, 8'hFF};
    foreach (l[i])
    begin
      sel(ISRP_SLAVE_WR, 1'b1);
      tx(l[i], 1'b0);
      chk8(ptr, 8'h0A, "pointer kept");
    end
    host_u.stop();
  endtask

  task automatic t_readonly();
    logic [7:0] l [4] = '{ISRP_RO_STATUS, ISRP_RO_CHARGE, ISRP_RO_CONV_HI, ISRP_RO_CONV_LO};
    foreach (l[i])
    begin
      sel(ISRP_SLAVE_WR, 1'b1);
      tx(l[i], 1'b1);
      n0 = n_stb;
      tx(8'h66, 1'b0);
      strobes(0);
      chk8(ptr, l[i], "read-only pointer");
      sel(ISRP_SLAVE_RD, 1'b1);
      rd(l[i] ^ 8'h5A);
    end
    host_u.stop();
  endtask

  task automatic t_abort();
    sel(ISRP_SLAVE_WR, 1'b1);
    tx(8'h06, 1'b1);
    n0 = n_stb;
    for (int i = 0; i < 5; i++)
      host_u.bit_io(1'b0, ack);
    host_u.stop();
    strobes(0);
    host_u.put(ISRP_SLAVE_WR, ack);
    chk1(ack, 1'b0, "bus ignored while waiting");
    sel(ISRP_SLAVE_RD, 1'b1);
    rd(8'h06 ^ 8'h5A);
    host_u.stop();
  endtask

  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_write();
    t_restart();
    t_foreign();
    t_reserved();
    t_readonly();
    t_abort();
    end_of_test();
  end
endmodule
